// ==== design/lgc_pkg.sv ====
// constants and types shared by the line interface global control block
`default_nettype none
package lgc_pkg;
    // register map and field positions
    localparam logic [15:0] LGC_REG_ADDR     = 16'h0fe0;
    localparam logic [7:0]  LGC_REG_RESET    = 8'h00;
    localparam int          LGC_BIT_SINGLE   = 7;
    localparam int          LGC_BIT_AUTO1    = 6;
    localparam int          LGC_BIT_RXEDGE   = 5;
    localparam int          LGC_BIT_TXEDGE   = 4;
    localparam int          LGC_BIT_POL      = 3;
    localparam int          LGC_BIT_UNUSED   = 2;
    localparam int          LGC_BIT_IRQ_EN   = 1;
    localparam int          LGC_BIT_SRST     = 0;
    // writable bits; the unused bit never stores
    localparam logic [7:0]  LGC_WR_MASK      = 8'hfb;
    // software reset hold time, strictly longer than the figure
    localparam int          LGC_CLK_PERIOD_NS = 25;
    localparam int          LGC_SRST_HOLD_NS  = 10000;
    localparam int          LGC_SRST_CYCLES   = LGC_SRST_HOLD_NS / LGC_CLK_PERIOD_NS + 1;
    // loss of signal zero run thresholds
    localparam int          LGC_LOS_ZEROS_STD = 175;
    localparam int          LGC_LOS_ZEROS_EXT = 4096;
    localparam int          LGC_LOS_CNT_W     = 13;
    // decoded control fields
    typedef struct packed {
        logic single_rail_select;
        logic auto_ones_on_signal_loss;
        logic receive_output_edge_select;
        logic transmit_sample_edge_select;
        logic data_polarity_select;
        logic global_interrupt_enable;
    } lgc_ctrl_t;
    // register contents to control fields
    function automatic lgc_ctrl_t lgc_decode(input logic [7:0] r);
        lgc_ctrl_t c;
        c.single_rail_select          = r[LGC_BIT_SINGLE];
        c.auto_ones_on_signal_loss    = r[LGC_BIT_AUTO1];
        c.receive_output_edge_select  = r[LGC_BIT_RXEDGE];
        c.transmit_sample_edge_select = r[LGC_BIT_TXEDGE];
        c.data_polarity_select        = r[LGC_BIT_POL];
        c.global_interrupt_enable     = r[LGC_BIT_IRQ_EN];
        return c;
    endfunction
endpackage
`default_nettype wire

// ==== design/lgc_los_det.sv ====
// per-channel receive signal loss detector counting consecutive zeros
`default_nettype none
module lgc_los_det (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_soft_rst,
    // line bit stream, already synchronised
    input  wire logic i_bit_valid,
    input  wire logic i_bit,
    input  wire logic i_ext_en,
    // loss indication
    output logic      o_loss
);
    import lgc_pkg::*;

    logic [LGC_LOS_CNT_W-1:0] cnt_r;
    logic [LGC_LOS_CNT_W-1:0] cnt_nxt;
    logic                     loss_r;
    logic                     loss_nxt;
    logic [LGC_LOS_CNT_W-1:0] thr;

    // threshold and zero run counter, saturating at the threshold
    always_comb begin
        thr = i_ext_en ? LGC_LOS_CNT_W'(LGC_LOS_ZEROS_EXT)
                       : LGC_LOS_CNT_W'(LGC_LOS_ZEROS_STD);
        cnt_nxt  = cnt_r;
        loss_nxt = loss_r;
        if (i_soft_rst) begin
            cnt_nxt  = '0;
            loss_nxt = 1'b0;
        end else if (i_bit_valid) begin
            if (i_bit) begin
                cnt_nxt  = '0;
                loss_nxt = 1'b0;
            end else begin
                if (cnt_r < thr)
                    cnt_nxt = cnt_r + 1'b1;
                loss_nxt = (cnt_r + 1'b1 >= thr);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r  <= '0;
            loss_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            loss_r <= loss_nxt;
        end
    end

    assign o_loss = loss_r;

    chk_loss_needs_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_bit_valid && i_bit && !i_soft_rst) |=> !o_loss)
        else $error("loss held after a one was received");
    chk_loss_std_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ($rose(o_loss) && !i_ext_en) |-> ($past(cnt_r) == LGC_LOS_CNT_W'(LGC_LOS_ZEROS_STD - 1)))
        else $error("standard loss declared at wrong zero count");
endmodule
`default_nettype wire

// ==== design/lgc_top.sv ====
// line interface global control register and its controlled datapath
`default_nettype none
module lgc_top #(
    parameter int N_CH = 8
) (
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst_b,
    // processor register port
    input  wire logic                i_cs,
    input  wire logic                i_wr,
    input  wire logic [15:0]         i_addr,
    input  wire logic [7:0]          i_wdata,
    output logic      [7:0]          o_rdata,
    // per-channel interrupt sources
    input  wire logic [N_CH-1:0]     i_src_status,
    input  wire logic [N_CH-1:0]     i_src_enable,
    output logic                     o_irq,
    // receive line, bit strobe from the line clock recovery
    input  wire logic [N_CH-1:0]     i_rx_line,
    input  wire logic [N_CH-1:0]     i_rx_strobe,
    input  wire logic                i_ext_loss_en,
    output logic      [N_CH-1:0]     o_receive_signal_loss,
    // bypass rails
    input  wire logic [N_CH-1:0]     i_transmit_positive_rail,
    input  wire logic [N_CH-1:0]     i_transmit_negative_rail,
    output logic      [N_CH-1:0]     o_tx_line_pos,
    output logic      [N_CH-1:0]     o_tx_line_neg,
    output logic      [N_CH-1:0]     o_receive_positive_rail,
    output logic      [N_CH-1:0]     o_receive_negative_rail,
    // control levels to the line clocking logic
    output lgc_pkg::lgc_ctrl_t       o_ctrl,
    output logic                     o_soft_reset
);
    import lgc_pkg::*;

    localparam logic [8:0] SRST_CNT = 9'(LGC_SRST_CYCLES);

    logic [7:0]       reg_r;
    logic [7:0]       reg_nxt;
    logic [8:0]       srst_cnt_r;
    logic [8:0]       srst_cnt_nxt;
    logic             srst_r;
    logic             srst_nxt;
    logic [7:0]       rdata_r;
    logic [7:0]       rdata_nxt;
    logic             irq_r;
    logic             irq_nxt;
    lgc_ctrl_t        ctrl;
    logic             hit;
    // pin synchronisers, first stage read only by the second
    logic [N_CH-1:0]  rx_s1_r;
    logic [N_CH-1:0]  rx_s2_r;
    logic [N_CH-1:0]  stb_s1_r;
    logic [N_CH-1:0]  stb_s2_r;
    logic [N_CH-1:0]  stb_s3_r;
    logic [N_CH-1:0]  tp_s1_r;
    logic [N_CH-1:0]  tp_s2_r;
    logic [N_CH-1:0]  tn_s1_r;
    logic [N_CH-1:0]  tn_s2_r;
    logic [N_CH-1:0]  los;
    logic [N_CH-1:0]  txp_nxt;
    logic [N_CH-1:0]  txn_nxt;
    logic [N_CH-1:0]  txp_r;
    logic [N_CH-1:0]  txn_r;
    logic [N_CH-1:0]  rxp_r;
    logic [N_CH-1:0]  rxn_r;
    logic [N_CH-1:0]  rxp_nxt;
    logic [N_CH-1:0]  rxn_nxt;

    assign hit  = i_cs && (i_addr == LGC_REG_ADDR);
    assign ctrl = lgc_decode(reg_r);

    // register write, reset hold timer and read data
    always_comb begin
        reg_nxt      = reg_r;
        srst_cnt_nxt = srst_cnt_r;
        srst_nxt     = 1'b0;
        rdata_nxt    = rdata_r;
        if (hit && i_wr)
            reg_nxt = i_wdata & LGC_WR_MASK;
        if (hit && !i_wr)
            rdata_nxt = reg_r;
        else if (i_cs && !i_wr)
            rdata_nxt = 8'h00; // unmapped reads answer zero
        // request counts only while bit 0 stays high; a short pulse does nothing
        if (!reg_r[LGC_BIT_SRST]) begin
            srst_cnt_nxt = '0;
        end else if (srst_cnt_r == SRST_CNT - 9'h001) begin
            srst_nxt                 = 1'b1;
            srst_cnt_nxt             = '0;
            reg_nxt[LGC_BIT_SRST]    = 1'b0; // bit returns to 0, others kept
        end else begin
            srst_cnt_nxt = srst_cnt_r + 9'h001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            reg_r      <= LGC_REG_RESET;
            srst_cnt_r <= '0;
            srst_r     <= 1'b0;
            rdata_r    <= 8'h00;
        end else begin
            reg_r      <= reg_nxt;
            srst_cnt_r <= srst_cnt_nxt;
            srst_r     <= srst_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // interrupt gating, registered so the pin never glitches
    always_comb begin
        irq_nxt = ctrl.global_interrupt_enable && |(i_src_status & i_src_enable);
        if (srst_r)
            irq_nxt = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            irq_r <= 1'b0;
        else
            irq_r <= irq_nxt;
    end

    // two-flop synchronisers for the receive line, strobe and transmit rail inputs
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_s1_r  <= '0;
            rx_s2_r  <= '0;
            stb_s1_r <= '0;
            stb_s2_r <= '0;
            stb_s3_r <= '0;
            tp_s1_r  <= '0;
            tp_s2_r  <= '0;
            tn_s1_r  <= '0;
            tn_s2_r  <= '0;
        end else begin
            rx_s1_r  <= i_rx_line;
            rx_s2_r  <= rx_s1_r;
            stb_s1_r <= i_rx_strobe;
            stb_s2_r <= stb_s1_r;
            stb_s3_r <= stb_s2_r;
            tp_s1_r  <= i_transmit_positive_rail;
            tp_s2_r  <= tp_s1_r;
            tn_s1_r  <= i_transmit_negative_rail;
            tn_s2_r  <= tn_s1_r;
        end
    end

    // one detector per channel; a strobe rising edge marks one line bit
    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            lgc_los_det u_los (
                .i_clk       (i_clk),
                .i_rst_b     (i_rst_b),
                .i_soft_rst  (srst_r),
                .i_bit_valid (stb_s2_r[g] && !stb_s3_r[g]),
                .i_bit       (rx_s2_r[g]),
                .i_ext_en    (i_ext_loss_en),
                .o_loss      (los[g])
            );
        end
    endgenerate

    // rail datapath: polarity, then all ones substitution on loss
    always_comb begin
        txp_nxt = tp_s2_r ^ {N_CH{ctrl.data_polarity_select}};
        txn_nxt = tn_s2_r ^ {N_CH{ctrl.data_polarity_select}};
        if (ctrl.auto_ones_on_signal_loss) begin
            txp_nxt = txp_nxt | los;
            txn_nxt = txn_nxt | los;
        end
        // single rail carries data on the positive rail only
        if (ctrl.single_rail_select)
            txn_nxt = '0;
        rxp_nxt = rx_s2_r ^ {N_CH{ctrl.data_polarity_select}};
        rxn_nxt = ctrl.single_rail_select ? '0
                                          : ~rx_s2_r ^ {N_CH{ctrl.data_polarity_select}};
        if (srst_r) begin
            txp_nxt = '0;
            txn_nxt = '0;
            rxp_nxt = '0;
            rxn_nxt = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            txp_r <= '0;
            txn_r <= '0;
            rxp_r <= '0;
            rxn_r <= '0;
        end else begin
            txp_r <= txp_nxt;
            txn_r <= txn_nxt;
            rxp_r <= rxp_nxt;
            rxn_r <= rxn_nxt;
        end
    end

    // edge selects leave as levels; line clock logic applies them
    assign o_ctrl                  = ctrl;
    assign o_rdata                 = rdata_r;
    assign o_irq                   = irq_r;
    assign o_soft_reset            = srst_r;
    assign o_receive_signal_loss   = los;
    assign o_tx_line_pos           = txp_r;
    assign o_tx_line_neg           = txn_r;
    assign o_receive_positive_rail = rxp_r;
    assign o_receive_negative_rail = rxn_r;

    chk_irq_gen_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !$past(ctrl.global_interrupt_enable) |-> !o_irq)
        else $error("interrupt with global enable clear");
    chk_irq_needs_src: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_irq |-> $past(|(i_src_status & i_src_enable)))
        else $error("interrupt without an enabled source");
    chk_irq_or_and: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (ctrl.global_interrupt_enable && |(i_src_status & i_src_enable) && !srst_r)
            |=> o_irq)
        else $error("enabled source did not raise interrupt");
    chk_unused_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        reg_r[LGC_BIT_UNUSED] == 1'b0)
        else $error("unused bit stored a value");
    chk_srst_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_soft_reset) |-> $past(srst_cnt_r) == SRST_CNT - 9'h001)
        else $error("software reset before hold time");
    chk_srst_keeps_reg: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_soft_reset && !$past(hit && i_wr)) |-> reg_r[7:1] == $past(reg_r[7:1]))
        else $error("software reset changed register bits");
    chk_auto_ones: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (ctrl.auto_ones_on_signal_loss && los[0] && !srst_r) |=> o_tx_line_pos[0])
        else $error("no all ones during signal loss");
    chk_polarity: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!srst_r) |=> o_receive_positive_rail == ($past(rx_s2_r)
            ^ {N_CH{$past(ctrl.data_polarity_select)}}))
        else $error("receive polarity wrong");
    chk_single_rail: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ctrl.single_rail_select |=> o_tx_line_neg == '0)
        else $error("negative rail driven in single rail");
endmodule
`default_nettype wire

// ==== tb/line_iface_global_control_test.sv ====
// self-checking bench for the line interface global control block
`default_nettype none
module line_iface_global_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import lgc_pkg::*;
    localparam int N_CH  = 8;
    localparam int LIMIT = 60000;
    logic            i_clk;
    logic            i_rst_b;
    logic            i_cs;
    logic            i_wr;
    logic [15:0]     i_addr;
    logic [7:0]      i_wdata;
    logic [7:0]      o_rdata;
    logic [N_CH-1:0] i_src_status;
    logic [N_CH-1:0] i_src_enable;
    logic            o_irq;
    logic [N_CH-1:0] i_rx_line;
    logic [N_CH-1:0] i_rx_strobe;
    logic            i_ext_loss_en;
    logic [N_CH-1:0] o_receive_signal_loss;
    logic [N_CH-1:0] i_transmit_positive_rail;
    logic [N_CH-1:0] i_transmit_negative_rail;
    logic [N_CH-1:0] o_tx_line_pos;
    logic [N_CH-1:0] o_tx_line_neg;
    logic [N_CH-1:0] o_receive_positive_rail;
    logic [N_CH-1:0] o_receive_negative_rail;
    lgc_ctrl_t       o_ctrl;
    logic            o_soft_reset;
    int              miscompares = 0;
    int              comparisons = 0;
    int              cycles = 0;
    int              wait_n;
    logic [7:0]      rd;
    logic [7:0]      wv;

    lgc_top #(.N_CH(N_CH)) dut_u (
        .i_clk, .i_rst_b, .i_cs, .i_wr, .i_addr, .i_wdata, .o_rdata,
        .i_src_status, .i_src_enable, .o_irq,
        .i_rx_line, .i_rx_strobe, .i_ext_loss_en, .o_receive_signal_loss,
        .i_transmit_positive_rail, .i_transmit_negative_rail,
        .o_tx_line_pos, .o_tx_line_neg,
        .o_receive_positive_rail, .o_receive_negative_rail,
        .o_ctrl, .o_soft_reset
    );

    // 40 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic give_verdict;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard, sized well above the long zero run
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ctrl(input lgc_ctrl_t got, input lgc_ctrl_t exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // all accesses start and end at a falling edge
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        i_cs = 1'b1;
        i_wr = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_cs = 1'b0;
        i_wr = 1'b0;
        @(negedge i_clk); // idle edge so a following access never re-raises select at once
    endtask

    // extra cycle so either read latency reading is settled
    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        i_cs = 1'b1;
        i_wr = 1'b0;
        i_addr = a;
        @(negedge i_clk);
        i_cs = 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask

    task automatic irq_case(input logic [7:0] st, input logic [7:0] en,
                            input logic [7:0] cfg, input logic exp);
        i_src_status = st;
        i_src_enable = en;
        reg_wr(LGC_REG_ADDR, cfg);
        repeat (3) @(negedge i_clk);
        chk({7'h00, o_irq}, {7'h00, exp});
    endtask

    // bits on channel 0, strobe slow enough for the input synchroniser
    task automatic send_bits(input int n, input logic b);
        for (int k = 0; k < n; k++) begin
            i_rx_line[0] = b;
            i_rx_strobe[0] = 1'b1;
            repeat (3) @(negedge i_clk);
            i_rx_strobe[0] = 1'b0;
            repeat (3) @(negedge i_clk);
        end
        repeat (4) @(negedge i_clk);
    endtask

    initial begin
        i_rst_b = 1'b0;
        i_cs = 1'b0;
        i_wr = 1'b0;
        i_addr = 16'h0000;
        i_wdata = 8'h00;
        i_src_status = '0;
        i_src_enable = '0;
        i_rx_line = '0;
        i_rx_strobe = '0;
        i_ext_loss_en = 1'b0;
        i_transmit_positive_rail = '0;
        i_transmit_negative_rail = '0;
        repeat (10) @(negedge i_clk);
        i_rst_b = 1'b1;
        @(negedge i_clk);
        // reset value, then an unmapped place
        reg_rd(LGC_REG_ADDR, rd);
        chk(rd, 8'h00);
        reg_wr(16'h0fe1, 8'hff);
        reg_rd(16'h0fe1, rd);
        chk(rd, 8'h00);
        reg_rd(LGC_REG_ADDR, rd);
        chk(rd, 8'h00);
        // one bit at a time through every field except the software reset bit 0
        for (int k = 1; k < 8; k++) begin
            wv = 8'h01 << k;
            reg_wr(LGC_REG_ADDR, wv);
            reg_rd(LGC_REG_ADDR, rd);
            chk(rd, wv & 8'hfb);
            chk_ctrl(o_ctrl, {wv[7:3], wv[1]});
        end
        // interrupt gating
        irq_case(8'h01, 8'h01, 8'h00, 1'b0);
        irq_case(8'h01, 8'h02, 8'h02, 1'b0);
        irq_case(8'h81, 8'h81, 8'h02, 1'b1);
        irq_case(8'h80, 8'h01, 8'h02, 1'b0);
        // rails on channel 1 under polarity and coding
        i_rx_line[1] = 1'b1;
        i_transmit_positive_rail[1] = 1'b1;
        i_transmit_negative_rail[1] = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wv = {k[1], 3'h0, k[0], 3'h0};
            // framer side single rail setting lives outside this block
            reg_wr(LGC_REG_ADDR, wv);
            repeat (5) @(negedge i_clk);
            chk({4'h0, o_receive_positive_rail[1], o_receive_negative_rail[1],
                 o_tx_line_pos[1], o_tx_line_neg[1]},
                {4'h0, ~wv[3], wv[7] ? 1'b0 : wv[3],
                 ~wv[3], wv[7] ? 1'b0 : ~wv[3]});
        end
        // standard zero run threshold
        reg_wr(LGC_REG_ADDR, 8'h00);
        send_bits(174, 1'b0);
        chk({7'h00, o_receive_signal_loss[0]}, 8'h00);
        send_bits(1, 1'b0);
        chk({7'h00, o_receive_signal_loss[0]}, 8'h01);
        // all ones only while enabled
        for (int k = 0; k < 2; k++) begin
            reg_wr(LGC_REG_ADDR, {1'b0, k[0], 6'h00});
            repeat (5) @(negedge i_clk);
            chk({7'h00, o_tx_line_pos[0]}, {7'h00, k[0]});
        end
        // aborted request must restart the hold count
        reg_wr(LGC_REG_ADDR, 8'h8b);
        repeat (200) @(negedge i_clk);
        reg_wr(LGC_REG_ADDR, 8'h8a);
        reg_wr(LGC_REG_ADDR, 8'h8b);
        wait_n = 0;
        while (o_soft_reset !== 1'b1 && wait_n < 600) begin
            @(negedge i_clk);
            wait_n++;
        end
        // 400 cycles is 10 us; small slack for sampling phase
        chk({7'h00, wait_n >= 395 && wait_n <= 410}, 8'h01);
        repeat (2) @(negedge i_clk);
        chk({7'h00, o_receive_signal_loss[0]}, 8'h00);
        reg_rd(LGC_REG_ADDR, rd);
        chk(rd, 8'h8a);
        // extended zero run threshold
        reg_wr(LGC_REG_ADDR, 8'h00);
        i_ext_loss_en = 1'b1;
        send_bits(4095, 1'b0);
        chk({7'h00, o_receive_signal_loss[0]}, 8'h00);
        send_bits(1, 1'b0);
        chk({7'h00, o_receive_signal_loss[0]}, 8'h01);
        send_bits(1, 1'b1);
        chk({7'h00, o_receive_signal_loss[0]}, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
